// ### dv/lpm_cpu_model.sv
// Behavioural CPU core that sits beside the power control block.
// Assumes a register write that requests a mode ends its instruction.
`timescale 1ns/1ps
`default_nettype none
module lpm_cpu_model (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Observed core activity.
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_addr,
   input wire logic cpu_clk_en,
   // Core outputs.
   output logic instr_end,
   output logic cpu_ale,
   output logic cpu_program_store_strobe,
   output logic [7:0] port_zero_cpu_out,
   output logic [7:0] port_zero_cpu_oe_n
);
   logic [7:0] cnt_q;
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         cnt_q <= 8'h00;
         instr_end <= 1'b0;
      end
      else if (cpu_clk_en)
      begin
         cnt_q <= cnt_q + 8'h01;
         instr_end <= sfr_wr && (sfr_addr == 8'h87);
      end
      else
      begin
         instr_end <= 1'b0;
      end
   end
   // A stopped core holds its address strobe low and its program store strobe high.
   assign cpu_ale = cpu_clk_en ? cnt_q[0] : 1'b0;
   assign cpu_program_store_strobe = cpu_clk_en ? cnt_q[1] : 1'b1;
   assign port_zero_cpu_out = cnt_q ^ 8'hA5;
   assign port_zero_cpu_oe_n = 8'h00;
endmodule
`default_nettype wire

// ### dv/lpm_power_ctrl_tb_top.sv
// Self-checking bench of the power control block.
// Assumes the behavioural core model for instruction ends and strobes.
`timescale 1ns/1ps
`include "lpm_consts.svh"
`default_nettype none
module lpm_power_ctrl_tb_top;
   localparam int KBD = 8;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic por_rst = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic instr_end, irq_pending = 1'b0, irq_vector = 1'b0, ext_prog = 1'b0;
   logic cpu_ale, cpu_pss, cpu_clk_en, osc_run, mem_retain, sfr_init_req;
   logic port_hold, ale, pss;
   logic ext0_n = 1'b1, ext1_n = 1'b1, kbd_irq = 1'b0, usb_irq = 1'b0;
   lpm_pkg::lpm_wake_t wake_en = 4'h0;
   logic [7:0] p0_latch = 8'h5A;
   logic [7:0] p0_cpu_out, p0_cpu_oe_n, p0_out, p0_oe_n;
   int fail_count = 0;
   int n_checks = 0;
   int n;
   always #2 ref_clk = ~ref_clk;
   lpm_power_ctrl #(.KBD_WAKE_CLKS(KBD)) dut_u (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .por_rst(por_rst),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .instr_end(instr_end), .irq_pending(irq_pending),
      .irq_vector(irq_vector), .ext_prog(ext_prog), .cpu_ale(cpu_ale),
      .cpu_program_store_strobe(cpu_pss), .cpu_clk_en(cpu_clk_en),
      .ext_irq_zero_n(ext0_n), .external_irq_one_n(ext1_n),
      .kbd_irq(kbd_irq), .usb_irq(usb_irq), .wake_en(wake_en),
      .osc_run(osc_run), .mem_retain(mem_retain),
      .sfr_init_req(sfr_init_req), .port_hold(port_hold), .ale(ale),
      .program_store_strobe(pss), .port_zero_latch(p0_latch),
      .port_zero_cpu_out(p0_cpu_out), .port_zero_cpu_oe_n(p0_cpu_oe_n),
      .port_zero_out(p0_out), .port_zero_oe_n(p0_oe_n)
   );
   lpm_cpu_model cpu_u (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .sfr_wr(sfr_wr),
      .sfr_addr(sfr_addr), .cpu_clk_en(cpu_clk_en), .instr_end(instr_end),
      .cpu_ale(cpu_ale), .cpu_program_store_strobe(cpu_pss),
      .port_zero_cpu_out(p0_cpu_out), .port_zero_cpu_oe_n(p0_cpu_oe_n)
   );
   task automatic conclude();
      if (fail_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                      input string msg);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge ref_clk);
      sfr_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge ref_clk);
      sfr_rd <= 1'b0;
      #1;
      chk(sfr_rdata, exp, "register read");
   endtask
   task automatic vector();
      @(posedge ref_clk);
      irq_vector <= 1'b1;
      @(posedge ref_clk);
      irq_vector <= 1'b0;
   endtask
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      fail_count++;
      conclude();
   end
   initial
   begin
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      por_rst <= 1'b0;
      rd(`LPM_PWR_CTRL_ADDR, 8'h10);
      rd(8'h86, 8'h00);
      wr(`LPM_PWR_CTRL_ADDR, 8'h00);
      rd(`LPM_PWR_CTRL_ADDR, 8'h00);
      wr(`LPM_PWR_CTRL_ADDR, 8'h0D);
      tick(2);
      chk(cpu_clk_en, 1'b0, "idle gates core clock");
      chk(osc_run, 1'b1, "idle keeps oscillator");
      chk(mem_retain, 1'b1, "idle retains state");
      chk({port_hold, ale, pss}, 3'b111, "idle strobes high");
      chk(p0_oe_n, 8'h5A, "port zero drives zeros only");
      chk(p0_out, 8'h00, "port zero low data");
      @(posedge ref_clk);
      irq_pending <= 1'b1;
      @(posedge ref_clk);
      irq_pending <= 1'b0;
      tick(1);
      chk(cpu_clk_en, 1'b1, "interrupt ends idle");
      rd(`LPM_PWR_CTRL_ADDR, 8'h0C);
      wake_en <= 4'b0011;
      ext_prog <= 1'b1;
      wr(`LPM_PWR_CTRL_ADDR, 8'h03);
      tick(2);
      chk({osc_run, ale, pss}, 3'b000, "power-down stops oscillator");
      chk(p0_oe_n, 8'hFF, "port zero floats");
      irq_pending <= 1'b1;
      tick(2);
      chk(osc_run, 1'b0, "idle wake ignored in power-down");
      irq_pending <= 1'b0;
      ext0_n <= 1'b0;
      tick(2);
      chk({osc_run, cpu_clk_en}, 2'b10, "low pin restarts");
      tick(3);
      chk(cpu_clk_en, 1'b0, "exit waits for release");
      ext0_n <= 1'b1;
      tick(2);
      chk(cpu_clk_en, 1'b1, "release completes exit");
      rd(`LPM_PWR_CTRL_ADDR, 8'h03);
      vector();
      tick(2);
      chk(cpu_clk_en, 1'b1, "no idle after vector");
      rd(`LPM_PWR_CTRL_ADDR, 8'h00);
      wr(`LPM_PWR_CTRL_ADDR, 8'h02);
      tick(2);
      ext0_n <= 1'b0;
      ext1_n <= 1'b0;
      tick(3);
      ext1_n <= 1'b1;
      tick(2);
      chk(cpu_clk_en, 1'b1, "first release exits");
      ext0_n <= 1'b1;
      vector();
      usb_irq <= 1'b1;
      wr(`LPM_PWR_CTRL_ADDR, 8'h02);
      tick(3);
      chk(osc_run, 1'b0, "disabled source ignored");
      wake_en <= 4'b1011;
      tick(2);
      chk(cpu_clk_en, 1'b1, "enabled source wakes");
      usb_irq <= 1'b0;
      vector();
      wake_en <= 4'b0100;
      wr(`LPM_PWR_CTRL_ADDR, 8'h02);
      tick(2);
      kbd_irq <= 1'b1;
      n = 0;
      repeat (40)
      begin
         @(posedge ref_clk);
         kbd_irq <= 1'b0;
         #1;
         if (cpu_clk_en === 1'b1)
            break;
         if (osc_run === 1'b1)
            n++;
      end
      chk(8'(n), 8'(KBD), "keyboard wake delay");
      vector();
      wr(`LPM_PWR_CTRL_ADDR, 8'h1F);
      tick(2);
      chk(osc_run, 1'b0, "both bits act as power-down");
      sys_rst <= 1'b1;
      tick(24);
      chk({sfr_init_req, cpu_clk_en}, 2'b11, "reset reinitialises");
      sys_rst <= 1'b0;
      rd(`LPM_PWR_CTRL_ADDR, 8'h10);
      conclude();
   end
endmodule
`default_nettype wire

// ### src/lpm_consts.svh
// Constants of the low-power mode control block.
// Assumes inclusion by bare name from the design files.
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH
`define LPM_PWR_CTRL_ADDR 8'h87
`define LPM_PWR_CTRL_RST 8'h10
`define LPM_BIT_IDLE 0
`define LPM_BIT_PDOWN 1
`define LPM_BIT_GF0 2
`define LPM_BIT_GF1 3
`define LPM_BIT_POF 4
`define LPM_KBD_WAKE_CLKS 1024
`define LPM_RST_HOLD_OSC 24
`endif

// ### src/lpm_pkg.sv
// Types shared by the low-power mode control block.
// Assumes nothing of its surroundings.
package lpm_pkg;
   typedef enum logic [2:0] {
      LPM_RUN = 3'b000,
      LPM_IDLE = 3'b001,
      LPM_PDOWN = 3'b010,
      LPM_WAKE_WAIT = 3'b011,
      LPM_STARTUP = 3'b100
   } lpm_state_e;
   typedef logic [3:0] lpm_wake_t;
endpackage

// ### src/lpm_power_ctrl.sv
// Idle and power-down mode control with the power control register.
// Assumes a CPU core that gives instruction-end and vectoring pulses.
//
// Functional notes
// - Idle bit set: after that instruction gate CPU clock, keep peripherals.
// - Idle keeps all CPU state by freezing the CPU clock.
// - Idle holds port pins; address strobe and program strobe high.
// - Enabled interrupt in idle clears idle bit and resumes execution.
// - Power-down bit set stops oscillator after that instruction.
// - Power-down retains internal RAM and special function registers.
// - Only enabled ext0, ext1, keyboard and USB wake power-down.
// - Keyboard wake waits 1024 clocks before normal operation.
// - Low wake pin restarts oscillator; exit completes on release.
// - Both pins enabled: either low restarts, first release exits.
// - After wake interrupt, execution continues after power-down request.
// - Reset reinitialises registers; interrupt exit leaves them untouched.
// - Both bits set: power-down exit, both bits cleared, no idle.
// - Any reset clears the power-down bit.
// - Two general flags are plain read/write with no side effect.
// - Port zero in low power drives only zeros; ones float.
`timescale 1ns/1ps
`include "lpm_consts.svh"
`default_nettype none
module lpm_power_ctrl #(
   parameter int KBD_WAKE_CLKS = `LPM_KBD_WAKE_CLKS
) (
   // Clock and resets.
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic por_rst,
   // Special function register port.
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // CPU core.
   input wire logic instr_end,
   input wire logic irq_pending,
   input wire logic irq_vector,
   input wire logic ext_prog,
   input wire logic cpu_ale,
   input wire logic cpu_program_store_strobe,
   output logic cpu_clk_en,
   // Wake sources.
   input wire logic ext_irq_zero_n,
   input wire logic external_irq_one_n,
   input wire logic kbd_irq,
   input wire logic usb_irq,
   input wire lpm_pkg::lpm_wake_t wake_en,
   // Oscillator, memories and ports.
   output logic osc_run,
   output logic mem_retain,
   output logic sfr_init_req,
   output logic port_hold,
   output logic ale,
   output logic program_store_strobe,
   // Port zero.
   input wire logic [7:0] port_zero_latch,
   input wire logic [7:0] port_zero_cpu_out,
   input wire logic [7:0] port_zero_cpu_oe_n,
   output logic [7:0] port_zero_out,
   output logic [7:0] port_zero_oe_n
);
   lpm_pkg::lpm_state_e state_q;
   lpm_pkg::lpm_state_e state_d;
   logic idle_q;
   logic idle_d;
   logic pdown_q;
   logic pdown_d;
   logic [1:0] gflag_q;
   logic [1:0] gflag_d;
   logic pof_q;
   logic pof_d;
   logic [1:0] low_q;
   logic [1:0] low_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [1:0] pin_low;
   logic pin_released;
   logic kbd_wake;
   logic usb_wake;
   logic kbd_start;
   logic kbd_busy;
   logic kbd_done;
   logic any_rst;
   logic reg_hit;

   assign any_rst = sys_rst || por_rst;
   assign reg_hit = (sfr_addr == `LPM_PWR_CTRL_ADDR);

   lpm_wake_sel u_wake (
      .ext_irq_zero_n(ext_irq_zero_n),
      .external_irq_one_n(external_irq_one_n),
      .kbd_irq(kbd_irq),
      .usb_irq(usb_irq),
      .wake_en(wake_en),
      .low_mask(low_q),
      .pin_low(pin_low),
      .pin_released(pin_released),
      .kbd_wake(kbd_wake),
      .usb_wake(usb_wake)
   );

   lpm_wait_cnt #(
      .CYCLES(KBD_WAKE_CLKS)
   ) u_kbd_wait (
      .ref_clk(ref_clk),
      .sys_rst(any_rst),
      .start(kbd_start),
      .busy(kbd_busy),
      .done(kbd_done)
   );

   // Mode sequencer and register bits.
   always_comb
   begin
      state_d = state_q;
      idle_d = idle_q;
      pdown_d = pdown_q;
      gflag_d = gflag_q;
      pof_d = pof_q;
      low_d = low_q;
      kbd_start = 1'b0;
      rdata_d = 8'h00;
      if (sfr_wr && reg_hit && state_q == lpm_pkg::LPM_RUN)
      begin
         idle_d = sfr_wdata[`LPM_BIT_IDLE];
         pdown_d = sfr_wdata[`LPM_BIT_PDOWN];
         gflag_d[0] = sfr_wdata[`LPM_BIT_GF0];
         gflag_d[1] = sfr_wdata[`LPM_BIT_GF1];
         pof_d = sfr_wdata[`LPM_BIT_POF];
      end
      if (sfr_rd && reg_hit)
      begin
         rdata_d = {3'b000, pof_q, gflag_q, pdown_q, idle_q};
      end
      case (state_q)
         lpm_pkg::LPM_RUN:
         begin
            if (instr_end && pdown_q)
            begin
               state_d = lpm_pkg::LPM_PDOWN;
            end
            else if (instr_end && idle_q)
            begin
               state_d = lpm_pkg::LPM_IDLE;
            end
            if (irq_vector && pdown_q)
            begin
               idle_d = 1'b0;
               pdown_d = 1'b0;
            end
         end
         lpm_pkg::LPM_IDLE:
         begin
            if (irq_pending)
            begin
               idle_d = 1'b0;
               state_d = lpm_pkg::LPM_RUN;
            end
         end
         lpm_pkg::LPM_PDOWN:
         begin
            if (|pin_low)
            begin
               low_d = pin_low;
               state_d = lpm_pkg::LPM_WAKE_WAIT;
            end
            else if (kbd_wake)
            begin
               kbd_start = 1'b1;
               state_d = lpm_pkg::LPM_STARTUP;
            end
            else if (usb_wake)
            begin
               state_d = lpm_pkg::LPM_RUN;
            end
         end
         lpm_pkg::LPM_WAKE_WAIT:
         begin
            low_d = low_q | pin_low;
            if (pin_released)
            begin
               state_d = lpm_pkg::LPM_RUN;
            end
         end
         lpm_pkg::LPM_STARTUP:
         begin
            if (kbd_done)
            begin
               state_d = lpm_pkg::LPM_RUN;
            end
         end
         default:
         begin
            state_d = lpm_pkg::LPM_RUN;
         end
      endcase
   end

   // Reset clears the mode bits; only power-up touches the power-off flag.
   always_ff @(posedge ref_clk)
   begin
      if (any_rst)
      begin
         state_q <= lpm_pkg::LPM_RUN;
         idle_q <= 1'b0;
         pdown_q <= 1'b0;
         gflag_q <= 2'b00;
         low_q <= 2'b00;
         rdata_q <= 8'h00;
      end
      else
      begin
         state_q <= state_d;
         idle_q <= idle_d;
         pdown_q <= pdown_d;
         gflag_q <= gflag_d;
         low_q <= low_d;
         rdata_q <= rdata_d;
      end
      if (por_rst)
      begin
         pof_q <= 1'(`LPM_PWR_CTRL_RST >> `LPM_BIT_POF);
      end
      else if (!sys_rst)
      begin
         pof_q <= pof_d;
      end
   end

   // Clocks, strobes, retention and ports.
   always_comb
   begin
      cpu_clk_en = (state_q == lpm_pkg::LPM_RUN);
      osc_run = (state_q != lpm_pkg::LPM_PDOWN);
      mem_retain = (state_q != lpm_pkg::LPM_RUN);
      sfr_init_req = any_rst;
      port_hold = !cpu_clk_en;
      ale = cpu_ale;
      program_store_strobe = cpu_program_store_strobe;
      port_zero_out = port_zero_cpu_out;
      port_zero_oe_n = port_zero_cpu_oe_n;
      if (state_q == lpm_pkg::LPM_IDLE)
      begin
         ale = 1'b1;
         program_store_strobe = 1'b1;
      end
      else if (!cpu_clk_en)
      begin
         ale = 1'b0;
         program_store_strobe = 1'b0;
      end
      if (!cpu_clk_en)
      begin
         port_zero_out = 8'h00;
         port_zero_oe_n = ext_prog ? 8'hff : port_zero_latch;
      end
   end

   assign sfr_rdata = rdata_q;

   // Cycle count in keyboard start-up, read only by an assertion.
   logic [15:0] startup_cyc_q;
   always_ff @(posedge ref_clk)
   begin
      if (state_q == lpm_pkg::LPM_STARTUP)
      begin
         startup_cyc_q <= startup_cyc_q + 16'h0001;
      end
      else
      begin
         startup_cyc_q <= 16'h0000;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (any_rst);

   AST_IDLE_ENTER: assert property (
      state_q == lpm_pkg::LPM_RUN && instr_end && idle_q && !pdown_q
      |=> state_q == lpm_pkg::LPM_IDLE && !cpu_clk_en)
      else $error("Idle not entered after the requesting instruction.");
   AST_IDLE_STROBES: assert property (
      state_q == lpm_pkg::LPM_IDLE |-> ale && program_store_strobe && port_hold)
      else $error("Strobes not high or ports not held in idle.");
   AST_IDLE_EXIT: assert property (
      state_q == lpm_pkg::LPM_IDLE && irq_pending
      |=> state_q == lpm_pkg::LPM_RUN && !idle_q && cpu_clk_en)
      else $error("Enabled interrupt did not end idle.");
   AST_PD_OSC: assert property (
      state_q == lpm_pkg::LPM_RUN && instr_end && pdown_q
      |=> !osc_run && !cpu_clk_en)
      else $error("Oscillator still running in power-down.");
   AST_PD_HOLD: assert property (
      state_q == lpm_pkg::LPM_PDOWN && !(|pin_low) && !kbd_wake && !usb_wake
      |=> $stable(gflag_q) && $stable(pof_q) && state_q == lpm_pkg::LPM_PDOWN)
      else $error("Power-down left without a wake source.");
   AST_KBD_WAIT: assert property (
      state_q == lpm_pkg::LPM_STARTUP ##1 state_q == lpm_pkg::LPM_RUN
      |-> $past(startup_cyc_q) == 16'(KBD_WAKE_CLKS - 1))
      else $error("Keyboard wake start-up length wrong.");
   AST_PIN_WAIT: assert property (
      state_q == lpm_pkg::LPM_WAKE_WAIT && !pin_released
      |=> state_q == lpm_pkg::LPM_WAKE_WAIT && osc_run && !cpu_clk_en)
      else $error("Power-down exit completed while wake pin low.");
   AST_FIRST_LOW: assert property (
      state_q == lpm_pkg::LPM_PDOWN && (|pin_low)
      |=> osc_run ##0 state_q == lpm_pkg::LPM_WAKE_WAIT)
      else $error("Low wake pin did not restart the oscillator.");
   AST_BOTH_CLEAR: assert property (
      state_q == lpm_pkg::LPM_RUN && pdown_q && irq_vector && !sfr_wr
      |=> !pdown_q && !idle_q ##1 state_q != lpm_pkg::LPM_IDLE)
      else $error("Mode bits not cleared on vectoring.");
   AST_PD_RESET: assert property (@(posedge ref_clk)
      $past(sys_rst) && !sys_rst |-> !pdown_q && state_q == lpm_pkg::LPM_RUN)
      else $error("Reset did not clear power-down bit.");
   AST_GFLAGS: assert property (
      sfr_wr && reg_hit && state_q == lpm_pkg::LPM_RUN
      |=> gflag_q == $past(sfr_wdata[3:2]) && state_q == lpm_pkg::LPM_RUN)
      else $error("General flags not written.");
   AST_PORT_ZERO: assert property (
      !cpu_clk_en && !ext_prog
      |-> port_zero_out == 8'h00 && port_zero_oe_n == port_zero_latch)
      else $error("Port zero drives a one in low-power mode.");
   AST_POF_SET: assert property (@(posedge ref_clk)
      $past(por_rst) && !por_rst |-> pof_q)
      else $error("Power-off flag not set at power-up.");

   COV_IDLE_WAKE: cover property (
      state_q == lpm_pkg::LPM_IDLE ##1 state_q == lpm_pkg::LPM_RUN);
   COV_PIN_WAKE: cover property (
      state_q == lpm_pkg::LPM_WAKE_WAIT ##1 state_q == lpm_pkg::LPM_RUN);
   COV_KBD_WAKE: cover property (
      state_q == lpm_pkg::LPM_STARTUP ##1 state_q == lpm_pkg::LPM_RUN);
endmodule
`default_nettype wire

// ### src/lpm_wait_cnt.sv
// Cycle counter that pulses done after a fixed number of cycles.
// Assumes start is a one-cycle pulse on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module lpm_wait_cnt #(
   parameter int CYCLES = 1024
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Control.
   input wire logic start,
   output logic busy,
   output logic done
);
   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic busy_q;
   logic busy_d;

   always_comb
   begin
      cnt_d = cnt_q;
      busy_d = busy_q;
      if (start)
      begin
         cnt_d = '0;
         busy_d = 1'b1;
      end
      else if (busy_q)
      begin
         if (cnt_q == LAST)
         begin
            busy_d = 1'b0;
         end
         cnt_d = cnt_q + W'(1);
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         cnt_q <= '0;
         busy_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         busy_q <= busy_d;
      end
   end

   assign busy = busy_q;
   assign done = busy_q && (cnt_q == LAST);
endmodule
`default_nettype wire

// ### src/lpm_wake_sel.sv
// Selects enabled power-down wake sources and tracks pin release.
// Assumes external interrupt pins are active low and synchronous.
`timescale 1ns/1ps
`default_nettype none
module lpm_wake_sel (
   // Wake sources and enables (0 ext0, 1 ext1, 2 keyboard, 3 USB).
   input wire logic ext_irq_zero_n,
   input wire logic external_irq_one_n,
   input wire logic kbd_irq,
   input wire logic usb_irq,
   input wire lpm_pkg::lpm_wake_t wake_en,
   // Low pins remembered at oscillator restart.
   input wire logic [1:0] low_mask,
   // Results.
   output logic [1:0] pin_low,
   output logic pin_released,
   output logic kbd_wake,
   output logic usb_wake
);
   always_comb
   begin
      pin_low[0] = wake_en[0] && !ext_irq_zero_n;
      pin_low[1] = wake_en[1] && !external_irq_one_n;
      pin_released = |(low_mask & ~pin_low);
      kbd_wake = wake_en[2] && kbd_irq;
      usb_wake = wake_en[3] && usb_irq;
   end
endmodule
`default_nettype wire
